// >>> hdl/spi_front_end.sv
// Front end of a serial memory: pin handling, state and user-side byte ports.
`timescale 1ns/100ps
module spi_front_end #(
  parameter logic [255:0] valid_mask = spi_front_pkg::valid_mask_default,
  parameter logic [255:0] read_mask = spi_front_pkg::read_mask_default
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic sclk_in,
  input wire logic sel_n_in,
  input wire logic serial_in,
  input wire logic hold_n_in,
  input wire logic wp_n_in,
  output logic serial_out,
  output logic serial_oe_out,
  output logic [7:0] rx_data_out,
  output logic rx_valid_out,
  output logic rx_instr_out,
  input wire logic [7:0] tx_data_in,
  input wire logic tx_write_in,
  output logic tx_taken_out,
  input wire logic protect_write_in,
  input wire logic [1:0] protect_bits_in,
  output logic block_protect_hi_out,
  output logic block_protect_lo_out,
  output logic selected_out,
  output logic held_out,
  output logic standby_out,
  output logic armed_out
);
  import spi_front_pkg::*;

  // The shifter runs on the serial clock and owns the serial data bit timing; this side
  // only sees its results through toggles and slow levels on the interface.
  link_if lnk ();

  spi_link_shifter #(
    .valid_mask(valid_mask),
    .read_mask(read_mask)
  ) u_shifter (
    .sclk_in(sclk_in),
    .sel_n_in(sel_n_in),
    .hold_n_in(hold_n_in),
    .serial_in(serial_in),
    .lnk(lnk)
  );

  // The output bit comes straight from the shifter's falling-edge flip-flop.
  assign serial_out = lnk.out_bit;

  // Pins and serial-clock signals that the control reads, except rx_byte and rx_first.
  logic [n_cross-1:0] cross_raw;
  logic [n_cross-1:0] cross_filt;

  assign cross_raw[x_sel_n] = sel_n_in;
  assign cross_raw[x_hold_n] = hold_n_in;
  assign cross_raw[x_wp_n] = wp_n_in;
  assign cross_raw[x_rx_tog] = lnk.rx_tog;
  assign cross_raw[x_tx_tog] = lnk.tx_tog;
  assign cross_raw[x_drive] = lnk.drive;
  assign cross_raw[x_standby] = lnk.standby;

  // Three-stage chains; a new level counts once the last two stages agree,
  // which also rejects a single-cycle glitch on a slow pin edge.
  // The cost is about four system clocks from a pin change to its use, so
  // the control side always lags the link; every decision below is taken
  // on levels that stand far longer than that, never on single edges of
  // the serial clock.
  genvar i;
  for (i = 0; i < n_cross; i++) begin : g_cross
    logic [sync_stages-1:0] chain;
    logic filt;
    always_ff @(posedge clock_in) begin
      if (rst_in) begin
        chain <= {sync_stages{cross_reset[i]}};
        filt <= cross_reset[i];
      end else begin
        chain <= {chain[sync_stages-2:0], cross_raw[i]};
        if (chain[sync_stages-1] == chain[sync_stages-2]) begin
          filt <= chain[sync_stages-1];
        end
      end
    end
    assign cross_filt[i] = filt;
  end

  // Decoded levels from the filtered chains.
  logic sel_now;
  logic hold_now;
  logic wp_now;
  logic drive_now;
  logic standby_now;

  assign sel_now = !cross_filt[x_sel_n];
  assign hold_now = !cross_filt[x_hold_n] && sel_now;
  assign wp_now = !cross_filt[x_wp_n];
  assign drive_now = cross_filt[x_drive];
  assign standby_now = cross_filt[x_standby];

  // Select as seen one cycle earlier; a fresh fall of select ends standby.
  logic sel_prev;
  logic sel_fall;

  assign sel_fall = sel_now && !sel_prev;

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      sel_prev <= ~cross_reset[x_sel_n];
    end else begin
      sel_prev <= sel_now;
    end
  end

  // Previous toggle values, to turn each toggle change into one event.
  logic rx_tog_prev;
  logic tx_tog_prev;
  logic rx_event;
  logic tx_event;

  // A rising select clears the toggles in the shifter, which would look like
  // one more byte. That clear crosses on the same edge as select itself, so
  // an event only counts while select is still seen low.
  assign rx_event = cross_filt[x_rx_tog] != rx_tog_prev && sel_now;
  assign tx_event = cross_filt[x_tx_tog] != tx_tog_prev && sel_now;

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      rx_tog_prev <= 1'b0;
      tx_tog_prev <= 1'b0;
    end else begin
      rx_tog_prev <= cross_filt[x_rx_tog];
      tx_tog_prev <= cross_filt[x_tx_tog];
    end
  end

  // Front end state as seen from the system clock.
  core_state_t state;
  core_state_t next_state;

  // Arming waits for select to be seen high, so a part that wakes up
  // with select already low ignores that first, partial frame.
  // Selected covers a frame in progress; held pauses it; standby follows a
  // refused instruction and lasts through the deselect until select falls
  // again, so the status shows the refusal until the next frame begins.
  always_comb begin
    next_state = state;
    case (state)
      wait_arm_st: begin
        if (!sel_now) begin
          next_state = deselected_st;
        end
      end
      deselected_st: begin
        if (sel_now) begin
          next_state = selected_st;
        end
      end
      selected_st: begin
        if (!sel_now) begin
          next_state = deselected_st;
        end else if (standby_now) begin
          next_state = standby_st;
        end else if (hold_now) begin
          next_state = held_st;
        end
      end
      held_st: begin
        if (!sel_now) begin
          next_state = deselected_st;
        end else if (!hold_now) begin
          next_state = selected_st;
        end
      end
      standby_st: begin
        if (sel_fall) begin
          next_state = selected_st;
        end
      end
      default: begin
        next_state = wait_arm_st;
      end
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      state <= wait_arm_st;
    end else begin
      state <= next_state;
    end
  end

  // Selected covers a held frame too: hold pauses, it does not deselect.
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      selected_out <= 1'b0;
    end else begin
      selected_out <= next_state == selected_st || next_state == held_st;
    end
  end

  // Hold status, only ever entered from the selected state.
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      held_out <= 1'b0;
    end else begin
      held_out <= next_state == held_st;
    end
  end

  // Standby status after a refused instruction.
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      standby_out <= 1'b0;
    end else begin
      standby_out <= next_state == standby_st;
    end
  end

  // Armed once select has been seen high after reset.
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      armed_out <= 1'b0;
    end else begin
      armed_out <= next_state != wait_arm_st;
    end
  end

  // Output enable: only while selected, not held, not in standby, and the
  // shifter has begun a read. The pin path adds a few cycles of delay,
  // which stays well inside the output disable time.
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      serial_oe_out <= 1'b0;
    end else begin
      serial_oe_out <= next_state == selected_st && drive_now && !hold_now;
    end
  end

  // Received bytes go out as one-cycle pulses; bytes from an unarmed frame
  // are dropped because the state never left the arming wait.
  // The byte itself crosses without a chain: it stands for eight serial
  // clocks after its toggle, far longer than the toggle takes to cross.
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      rx_data_out <= byte_reset;
      rx_valid_out <= 1'b0;
      rx_instr_out <= 1'b0;
    end else begin
      rx_valid_out <= 1'b0;
      if (rx_event && (state == selected_st || state == held_st)) begin
        rx_data_out <= lnk.rx_byte;
        rx_instr_out <= lnk.rx_first;
        rx_valid_out <= 1'b1;
      end
    end
  end

  // Transmit byte holding register, read by the shifter on falling edges.
  // The user must refill it within one byte time after each taken pulse.
  // It crosses to the serial clock without a handshake; that is safe only
  // because the shifter reads it a byte time after the taken pulse, when a
  // refill has long settled. A late refill sends the previous byte again.
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      lnk.tx_byte <= byte_reset;
      tx_taken_out <= 1'b0;
    end else begin
      tx_taken_out <= tx_event && state != wait_arm_st;
      if (tx_write_in) begin
        lnk.tx_byte <= tx_data_in;
      end
    end
  end

  // Block protect pair: a write is ignored while write protect is low, so
  // the protected region cannot grow or shrink.
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      block_protect_hi_out <= protect_reset[protect_hi_pos];
      block_protect_lo_out <= protect_reset[protect_lo_pos];
    end else if (protect_write_in && !wp_now) begin
      block_protect_hi_out <= protect_bits_in[protect_hi_pos];
      block_protect_lo_out <= protect_bits_in[protect_lo_pos];
    end
  end

endmodule : spi_front_end

// >>> hdl/spi_front_pkg.sv
// Shared constants and types for the serial memory front end.
package spi_front_pkg;

  // Width of one serial byte and the index of its last bit.
  localparam int unsigned byte_bits = 8;
  localparam logic [2:0] last_bit = 3'h7;
  localparam logic [2:0] first_bit = 3'h0;

  // Number of flip-flops in each crossing chain into the system clock.
  localparam int unsigned sync_stages = 3;

  // Positions of the signals that cross into the system clock domain.
  localparam int unsigned n_cross = 7;
  localparam int unsigned x_sel_n = 0;
  localparam int unsigned x_hold_n = 1;
  localparam int unsigned x_wp_n = 2;
  localparam int unsigned x_rx_tog = 3;
  localparam int unsigned x_tx_tog = 4;
  localparam int unsigned x_drive = 5;
  localparam int unsigned x_standby = 6;

  // Reset values of the crossing chains.
  // Select resets to low so a real high level must be seen before arming.
  localparam logic [6:0] cross_reset = 7'h06;

  // Opcode tables: bit n set means opcode n is valid, or is a read.
  localparam logic [255:0] valid_mask_default = {1'b0, {254{1'b1}}, 1'b0};
  localparam logic [255:0] read_mask_default = {128{2'h2}};

  // Reset value of the block protect pair.
  localparam logic [1:0] protect_reset = 2'h0;
  localparam int unsigned protect_hi_pos = 1;
  localparam int unsigned protect_lo_pos = 0;

  // Receive byte reset value.
  localparam logic [7:0] byte_reset = 8'h00;

  // States of the front end as seen from the system clock.
  typedef enum logic [2:0] {
    wait_arm_st,
    deselected_st,
    selected_st,
    held_st,
    standby_st
  } core_state_t;

endpackage : spi_front_pkg

// >>> hdl/link_if.sv
// Signals passed between the serial-clock shifter and the system-clock control.
`timescale 1ns/100ps
interface link_if;
  logic [7:0] rx_byte;
  logic rx_first;
  logic rx_tog;
  logic tx_tog;
  logic drive;
  logic standby;
  logic out_bit;
  logic [7:0] tx_byte;

  // The shifter side runs on the serial clock.
  modport link (
    output rx_byte, rx_first, rx_tog, tx_tog, drive, standby, out_bit,
    input tx_byte
  );

  // The control side runs on the system clock.
  modport core (
    input rx_byte, rx_first, rx_tog, tx_tog, drive, standby, out_bit,
    output tx_byte
  );
endinterface : link_if

// >>> hdl/spi_link_shifter.sv
// Serial-clock shifter: assembles input bytes and shifts output bytes.
`timescale 1ns/100ps
module spi_link_shifter #(
  parameter logic [255:0] valid_mask = spi_front_pkg::valid_mask_default,
  parameter logic [255:0] read_mask = spi_front_pkg::read_mask_default
) (
  input wire logic sclk_in,
  input wire logic sel_n_in,
  input wire logic hold_n_in,
  input wire logic serial_in,
  link_if.link lnk
);
  import spi_front_pkg::*;

  logic [2:0] bit_cnt;
  logic [6:0] shreg;
  logic [6:0] tx_shift;
  logic got_instr;
  logic reading;
  logic [7:0] next_byte;

  // Byte as it stands after the bit now on the input line.
  assign next_byte = {shreg, serial_in};

  // Rising edges sample the input; a high select clears everything at once,
  // so each frame starts at bit zero whatever the clock polarity at rest.
  // Hold and input are sampled directly: the protocol keeps them stable
  // around the clock edges, so they belong to this clock.
  always_ff @(posedge sclk_in or posedge sel_n_in) begin
    if (sel_n_in) begin
      bit_cnt <= first_bit;
      shreg <= 7'h00;
      got_instr <= 1'b0;
      reading <= 1'b0;
      lnk.standby <= 1'b0;
      lnk.rx_byte <= byte_reset;
      lnk.rx_first <= 1'b0;
      lnk.rx_tog <= 1'b0;
    end else if (hold_n_in && !lnk.standby) begin
      shreg <= next_byte[6:0];
      bit_cnt <= bit_cnt + 3'h1;
      if (bit_cnt == last_bit) begin
        got_instr <= 1'b1;
        if (!got_instr && !valid_mask[next_byte]) begin
          lnk.standby <= 1'b1;
        end else begin
          lnk.rx_byte <= next_byte;
          lnk.rx_first <= !got_instr;
          lnk.rx_tog <= ~lnk.rx_tog;
          if (!got_instr) begin
            reading <= read_mask[next_byte];
          end
        end
      end
    end
  end

  // Falling edges move the output; the first bit follows the instruction.
  always_ff @(negedge sclk_in or posedge sel_n_in) begin
    if (sel_n_in) begin
      tx_shift <= 7'h00;
      lnk.out_bit <= 1'b0;
      lnk.drive <= 1'b0;
      lnk.tx_tog <= 1'b0;
    end else if (hold_n_in && reading) begin
      if (bit_cnt == first_bit) begin
        lnk.out_bit <= lnk.tx_byte[7];
        tx_shift <= lnk.tx_byte[6:0];
        lnk.tx_tog <= ~lnk.tx_tog;
        lnk.drive <= 1'b1;
      end else begin
        lnk.out_bit <= tx_shift[6];
        tx_shift <= {tx_shift[5:0], 1'b0};
      end
    end
  end

endmodule : spi_link_shifter

// >>> tb/spi_front_checker.sv
// Concurrent checks on the pins and user ports of the serial memory front end.
`timescale 1ns/100ps
module spi_front_checker (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic sel_n_in,
  input wire logic hold_n_in,
  input wire logic wp_n_in,
  input wire logic serial_oe_out,
  input wire logic rx_valid_out,
  input wire logic rx_instr_out,
  input wire logic protect_write_in,
  input wire logic [1:0] protect_bits_in,
  input wire logic block_protect_hi_out,
  input wire logic block_protect_lo_out,
  input wire logic held_out,
  input wire logic standby_out,
  input wire logic armed_out
);
  // All checks run on the system clock; eight cycles cover the sync chains.
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (rst_in);

  // Pin and state checks.
  a_desel_out_off: assert property (sel_n_in [*8] |-> !held_out && !serial_oe_out)
    else $error("output driven or hold while deselected");
  a_hold_out_off: assert property ((!sel_n_in && !hold_n_in) [*8] |->
    held_out && !serial_oe_out)
    else $error("hold not in effect while selected");
  a_rx_one_pulse: assert property (rx_valid_out |=> !rx_valid_out)
    else $error("receive strobe longer than one cycle");
  a_unarmed_no_rx: assert property (!armed_out |-> !rx_valid_out)
    else $error("byte reported before arming");
  a_rx_while_sel: assert property (rx_valid_out |-> !sel_n_in)
    else $error("byte reported while deselected");
  a_standby_quiet: assert property (standby_out |-> !rx_valid_out && !serial_oe_out)
    else $error("activity in standby");
  // A protect write is refused while write protect is low and taken while high.
  a_protect_frozen: assert property (!wp_n_in [*6] ##1 protect_write_in |=>
    $stable({block_protect_hi_out, block_protect_lo_out}))
    else $error("protect bits changed under write protect");
  a_protect_loads: assert property (wp_n_in [*6] ##1 protect_write_in |=>
    {block_protect_hi_out, block_protect_lo_out} == $past(protect_bits_in))
    else $error("protect bits not loaded");

  // Main scenarios reached.
  c_instr: cover property (rx_valid_out && rx_instr_out);
  c_read: cover property ($rose(serial_oe_out));
  c_standby: cover property (standby_out);
  c_held: cover property (held_out);
endmodule : spi_front_checker

bind spi_front_end spi_front_checker chk (.clock_in, .rst_in, .sel_n_in, .hold_n_in,
  .wp_n_in, .serial_oe_out, .rx_valid_out, .rx_instr_out, .protect_write_in,
  .protect_bits_in, .block_protect_hi_out, .block_protect_lo_out, .held_out,
  .standby_out, .armed_out);

// >>> tb/spi_master_model.sv
// Behavioural SPI master with a 125 ns serial clock that stands still between frames.
`timescale 1ns/100ps
module spi_master_model (
  output logic sclk_out,
  output logic sel_n_out,
  output logic mosi_out,
  output logic hold_n_out,
  input wire logic miso_in
);
  // Power-up bus: selected, hold released.
  initial begin
    sclk_out = 1'b0;
    sel_n_out = 1'b0;
    mosi_out = 1'b0;
    hold_n_out = 1'b1;
    // A clean rise of select clears the shifter before the first frame.
    #20 sel_n_out = 1'b1;
  end

  // One frame, d sent from its top bit down; hold pauses before bit hold_at.
  task automatic xfer(input bit cpol, input int nbits, input int hold_at,
                      input logic [31:0] d, output logic [31:0] q);
    q = 32'h0;
    sclk_out = cpol;
    #100 sel_n_out = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      #62.5 sclk_out = 1'b0;
      mosi_out = d[31 - i];
      // Hold moves only with the clock low; the clock and data wiggle meanwhile.
      if (i == hold_at) begin
        hold_n_out = 1'b0;
        #300 sclk_out = 1'b1;
        mosi_out = ~mosi_out;
        #100 sclk_out = 1'b0;
        #300 hold_n_out = 1'b1;
        mosi_out = d[31 - i];
      end
      #62.5 sclk_out = 1'b1;
      q = {q[30:0], miso_in};
    end
    #62.5 sclk_out = cpol;
    #62.5 sel_n_out = 1'b1;
    mosi_out = ~mosi_out;
    #200;
  endtask : xfer
endmodule : spi_master_model

// >>> tb/serial_memory_spi_front_end_tb_top.sv
// Self-checking bench for the serial memory front end driven by a master model.
`timescale 1ns/100ps
module serial_memory_spi_front_end_tb_top;
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic sclk_in, sel_n_in, serial_in, hold_n_in;
  logic wp_n_in = 1'b1;
  logic [7:0] tx_data_in = 8'h00;
  logic tx_write_in = 1'b0;
  logic protect_write_in = 1'b0;
  logic [1:0] protect_bits_in = 2'h0;
  logic serial_out, serial_oe_out, rx_valid_out, rx_instr_out, tx_taken_out;
  logic block_protect_hi_out, block_protect_lo_out;
  logic selected_out, held_out, standby_out, armed_out, load;
  logic [7:0] rx_data_out;
  logic [31:0] q;
  logic [8:0] rxq[$];
  logic oe_seen, sb_seen, hd_seen, sl_seen;
  int mismatches = 0;
  int check_count = 0;
  int tk_cnt = 0;

  spi_front_end DUT (.clock_in, .rst_in, .sclk_in, .sel_n_in, .serial_in, .hold_n_in,
    .wp_n_in, .serial_out, .serial_oe_out, .rx_data_out, .rx_valid_out, .rx_instr_out,
    .tx_data_in, .tx_write_in, .tx_taken_out, .protect_write_in, .protect_bits_in,
    .block_protect_hi_out, .block_protect_lo_out, .selected_out, .held_out,
    .standby_out, .armed_out);
  // A released output shows the inverse of its last bit, so a bit read
  // before the output enable rises cannot pass by chance.
  spi_master_model spi (.sclk_out(sclk_in), .sel_n_out(sel_n_in), .mosi_out(serial_in),
    .hold_n_out(hold_n_in), .miso_in(serial_oe_out ? serial_out : ~serial_out));

  // System clock at 100 MHz.
  initial forever #5 clock_in = ~clock_in;

  // Outputs are sampled mid-cycle, where registered values have settled.
  always @(negedge clock_in) begin
    if (rx_valid_out === 1'b1)
      rxq.push_back({rx_instr_out, rx_data_out});
    oe_seen = oe_seen | (serial_oe_out === 1'b1);
    sb_seen = sb_seen | (standby_out === 1'b1);
    hd_seen = hd_seen | (held_out === 1'b1);
    sl_seen = sl_seen | (selected_out === 1'b1);
    if (tx_taken_out === 1'b1)
      tk_cnt++;
  end

  // Refill the send holding register whenever the shifter takes a byte.
  always @(negedge clock_in) begin
    tx_write_in <= load | (tx_taken_out === 1'b1);
    if (tx_taken_out === 1'b1)
      tx_data_in <= 8'h3a;
  end

  task check(input string what, input logic [8:0] seen, input logic [8:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task give_verdict;
    if (mismatches == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : give_verdict

  task pwrite(input logic [1:0] b);
    @(negedge clock_in);
    protect_bits_in = b;
    protect_write_in = 1'b1;
    @(negedge clock_in);
    protect_write_in = 1'b0;
    @(negedge clock_in);
  endtask : pwrite

  task t_protect;
    check("protect reset", 9'({block_protect_hi_out, block_protect_lo_out}),
          9'(spi_front_pkg::protect_reset));
    check("armed", 9'(armed_out), 9'h1);
    pwrite(2'h2);
    check("protect load", 9'({block_protect_hi_out, block_protect_lo_out}), 9'h2);
    wp_n_in = 1'b0;
    repeat (8) @(negedge clock_in);
    pwrite(2'h1);
    check("protect frozen", 9'({block_protect_hi_out, block_protect_lo_out}), 9'h2);
    wp_n_in = 1'b1;
  endtask : t_protect

  // An invalid opcode, then data; standby must outlast the frame.
  task t_invalid;
    rxq.delete();
    sb_seen = 1'b0;
    spi.xfer(1'b0, 16, 99, 32'hff11_0000, q);
    @(negedge clock_in);
    check("standby seen", 9'(sb_seen), 9'h1);
    check("standby kept", 9'(standby_out), 9'h1);
    check("rx count", 9'(rxq.size()), 9'h0);
  endtask : t_invalid

  // A write-type frame in mode 0 with a hold and clock noise in mid-byte.
  task t_write;
    rxq.delete();
    oe_seen = 1'b0;
    hd_seen = 1'b0;
    sl_seen = 1'b0;
    spi.xfer(1'b0, 16, 11, 32'h02a5_0000, q);
    @(negedge clock_in);
    check("rx count", 9'(rxq.size()), 9'h2);
    check("instr byte", rxq[0], 9'h102);
    check("data byte", rxq[1], 9'h0a5);
    check("held seen", 9'(hd_seen), 9'h1);
    check("no drive", 9'(oe_seen), 9'h0);
    check("standby left", 9'(standby_out), 9'h0);
    check("selected seen", 9'(sl_seen), 9'h1);
  endtask : t_write

  // A read frame in each clock mode, two bytes out back to back.
  task t_read;
    for (int m = 0; m < 2; m++) begin
      rxq.delete();
      oe_seen = 1'b0;
      @(negedge clock_in);
      tx_data_in = 8'h5c;
      load <= 1'b1;
      @(negedge clock_in);
      load <= 1'b0;
      tk_cnt = 0;
      spi.xfer(m[0], 24, 99, 32'h0300_0000, q);
      @(negedge clock_in);
      // Mode 0 ends on a falling edge that starts one more byte out.
      check("taken count", 9'(tk_cnt), 9'(3 - m));
      check("first out", 9'(q[15:8]), 9'h05c);
      check("second out", 9'(q[7:0]), 9'h03a);
      check("drive seen", 9'(oe_seen), 9'h1);
      check("instr read", rxq[0], 9'h103);
      check("oe released", 9'(serial_oe_out), 9'h0);
    end
  endtask : t_read

  // Main sequence: reset for 8 cycles, let select be seen high, then scenarios.
  initial begin
    load = 1'b0;
    sl_seen = 1'b0;
    oe_seen = 1'b0;
    sb_seen = 1'b0;
    hd_seen = 1'b0;
    repeat (8) @(negedge clock_in);
    rst_in = 1'b0;
    repeat (10) @(negedge clock_in);
    t_protect;
    t_invalid;
    t_write;
    t_read;
    give_verdict;
  end

  // Watchdog well beyond the roughly 13 us the scenarios need.
  initial begin
    #200000;
    mismatches++;
    give_verdict;
  end
endmodule : serial_memory_spi_front_end_tb_top
